// ---- rtl/bus_pin_assign.sv ----
// Port B and port E pin assignment with a classic Wishbone register slave.
// Assumes a steady operating mode, synchronous pin inputs and one clock.
`timescale 1ns/1ps
`include "bus_pin_map.svh"
module bus_pin_assign (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire bus_pin_pkg::mode_e mode_i,
    input  wire logic               emulate_port_e_bit_i,
    input  wire logic               bus_clock_stretch_i,
    input  wire logic               pullup_e_enable_i,
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_we_i,
    input  wire logic [7:0]         wb_adr_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic [31:0]        wb_dat_i,
    output logic      [31:0]        wb_dat_o,
    output logic                    wb_ack_o,
    input  wire logic [7:0]         bus_addr_i,
    input  wire logic [7:0]         bus_wdata_i,
    input  wire logic               bus_data_phase_i,
    input  wire logic               bus_data_drive_i,
    input  wire logic               data_bus_gate_i,
    input  wire logic               bus_phase_clock_i,
    input  wire logic               queue_status_hi_i,
    input  wire logic               queue_status_lo_i,
    input  wire logic               low_byte_strobe_i,
    input  wire logic               bus_rw_i,
    input  wire logic               trim_ref_i,
    input  wire logic               pll_test_signal_i,
    input  wire logic [7:0]         pb_i,
    output logic      [7:0]         pb_o,
    output logic      [7:0]         pb_oe_o,
    input  wire logic [7:0]         pe_i,
    output logic      [7:0]         pe_o,
    output logic      [7:0]         pe_oe_o,
    output logic      [7:0]         pe_pullup_o,
    output logic      [7:0]         bus_rdata_o,
    output logic                    tag_low_byte_o
);

    logic [7:0] port_b_pin_data_reg;
    logic [7:0] port_b_direction_reg;
    logic [7:0] port_e_pin_data_reg;
    logic [7:0] port_e_direction_reg;
    logic [7:0] port_e_function_select_reg;
    logic [7:0] written_reg;
    logic [7:0] write_ok;
    logic [7:0] fs_reset_value;
    logic [7:0] fs_next;
    logic [7:0] pb_next;
    logic [7:0] pb_oe_next;
    logic [7:0] pe_next;
    logic [7:0] pe_oe_next;
    logic [7:0] rd_next;
    logic [3:0] idx;
    logic       single;
    logic       expanded;
    logic       narrow;
    logic       periph;
    logic       special;
    logic       normal_exp;
    logic       b_mapped;
    logic       e_mapped;
    logic       fs_mapped;
    logic       wr;
    logic       rd;

    assign idx        = wb_adr_i[5:2];
    assign periph     = (mode_i == bus_pin_pkg::MODE_PERIPHERAL);
    assign single     = (mode_i == bus_pin_pkg::MODE_NORMAL_SINGLE) ||
                        (mode_i == bus_pin_pkg::MODE_SPECIAL_SINGLE);
    assign expanded   = !single && !periph;
    assign narrow     = (mode_i == bus_pin_pkg::MODE_NORMAL_NARROW) ||
                        (mode_i == bus_pin_pkg::MODE_SPECIAL_NARROW);
    assign normal_exp = (mode_i == bus_pin_pkg::MODE_NORMAL_NARROW) ||
                        (mode_i == bus_pin_pkg::MODE_NORMAL_WIDE);
    assign special    = (mode_i == bus_pin_pkg::MODE_SPECIAL_SINGLE) ||
                        (mode_i == bus_pin_pkg::MODE_SPECIAL_NARROW) ||
                        (mode_i == bus_pin_pkg::MODE_SPECIAL_WIDE) || periph;
    assign b_mapped   = single;
    assign e_mapped   = !periph && !(expanded && emulate_port_e_bit_i);
    assign fs_mapped  = !periph;
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && !wb_ack_o;
    assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;

    // Reset image of the function select register
    always_comb begin
        if (periph) begin
            fs_reset_value = `FS_RST_PERIPHERAL;
        end else if (mode_i == bus_pin_pkg::MODE_NORMAL_SINGLE) begin
            fs_reset_value = `FS_RST_NORMAL_SINGLE;
        end else if (normal_exp) begin
            fs_reset_value = `FS_RST_NORMAL_EXPANDED;
        end else begin
            fs_reset_value = `FS_RST_SPECIAL;
        end
    end

    // Per-bit write acceptance of the function select register
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_policy
            if (gi == `FS_TRIM_REFERENCE_ENABLE) begin : g_any
                assign write_ok[gi] = 1'b1;
            end else if (gi == `FS_PLL_TEST_OUT_ENABLE) begin : g_pll
                assign write_ok[gi] = special && written_reg[gi];
            end else if (gi == `FS_BUS_CLOCK_PIN_DISABLE) begin : g_clk
                assign write_ok[gi] =
                    (mode_i == bus_pin_pkg::MODE_SPECIAL_SINGLE) ||
                    ((mode_i == bus_pin_pkg::MODE_NORMAL_SINGLE) &&
                     !written_reg[gi]);
            end else begin : g_once
                assign write_ok[gi] = special ? written_reg[gi]
                                              : !written_reg[gi];
            end
        end
    endgenerate

    always_comb begin
        fs_next = port_e_function_select_reg;
        if (wr && fs_mapped && (idx == `IDX_PORT_E_FUNCTION_SELECT)) begin
            fs_next = (wb_dat_i[7:0] & write_ok) |
                      (port_e_function_select_reg & ~write_ok);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_e_function_select_reg <= fs_reset_value;
            written_reg                <= 8'h00;
        end else begin
            port_e_function_select_reg <= fs_next;
            if (wr && fs_mapped && (idx == `IDX_PORT_E_FUNCTION_SELECT)) begin
                written_reg <= 8'hff;
            end
        end
    end

    // Port data and direction registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_b_pin_data_reg  <= 8'h00;
            port_b_direction_reg <= 8'h00;
        end else if (wr && b_mapped) begin
            if (idx == `IDX_PORT_B_PIN_DATA) begin
                port_b_pin_data_reg <= wb_dat_i[7:0];
            end else if (idx == `IDX_PORT_B_DIRECTION) begin
                port_b_direction_reg <= wb_dat_i[7:0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            if (mode_i == bus_pin_pkg::MODE_NORMAL_NARROW) begin
                port_e_pin_data_reg  <= `PE3_RESET_DRIVE;
                port_e_direction_reg <= `PE3_RESET_DRIVE;
            end else begin
                port_e_pin_data_reg  <= 8'h00;
                port_e_direction_reg <= 8'h00;
            end
        end else if (wr && e_mapped) begin
            if (idx == `IDX_PORT_E_PIN_DATA) begin
                port_e_pin_data_reg <= wb_dat_i[7:0];
            end else if (idx == `IDX_PORT_E_DIRECTION) begin
                port_e_direction_reg <= wb_dat_i[7:0];
            end
        end
    end

    // Port B pin function
    always_comb begin
        if (single) begin
            pb_next    = port_b_pin_data_reg;
            pb_oe_next = port_b_direction_reg;
        end else if (narrow || !bus_data_phase_i) begin
            pb_next    = bus_addr_i;
            pb_oe_next = 8'hff;
        end else begin
            pb_next    = bus_wdata_i;
            pb_oe_next = {8{bus_data_drive_i}};
        end
    end

    // Port E pin function; alternate functions override direction
    always_comb begin
        pe_next    = port_e_pin_data_reg;
        pe_oe_next = port_e_direction_reg;
        pe_next[1:0]    = 2'b00;
        pe_oe_next[1:0] = 2'b00;
        if (port_e_function_select_reg[`FS_RW_PIN_ENABLE] && !single) begin
            pe_next[2]    = bus_rw_i;
            pe_oe_next[2] = 1'b1;
        end
        if (port_e_function_select_reg[`FS_LOW_STROBE_PIN_ENABLE] && !single &&
            (mode_i != bus_pin_pkg::MODE_NORMAL_NARROW)) begin
            pe_next[3]    = low_byte_strobe_i;
            pe_oe_next[3] = 1'b1;
        end
        if (!port_e_function_select_reg[`FS_BUS_CLOCK_PIN_DISABLE] &&
            (!single || !bus_clock_stretch_i)) begin
            pe_next[4]    = bus_phase_clock_i;
            pe_oe_next[4] = !periph;
        end
        if (port_e_function_select_reg[`FS_QUEUE_STATUS_OUT_ENABLE] && expanded) begin
            pe_next[6:5]    = {queue_status_hi_i, queue_status_lo_i};
            pe_oe_next[6:5] = 2'b11;
        end else if (port_e_function_select_reg[`FS_PLL_TEST_OUT_ENABLE] &&
                     !single && !normal_exp) begin
            pe_next[6]    = pll_test_signal_i;
            pe_oe_next[6] = 1'b1;
        end
        if (expanded && !port_e_function_select_reg[`FS_NO_DATA_GATE]) begin
            pe_next[7]    = port_e_function_select_reg[`FS_DATA_GATE_SELECT] ?
                            !bus_phase_clock_i : data_bus_gate_i;
            pe_oe_next[7] = 1'b1;
        end else if (port_e_function_select_reg[`FS_TRIM_REFERENCE_ENABLE]) begin
            pe_next[7]    = trim_ref_i;
            pe_oe_next[7] = 1'b1;
        end
    end

    // Read data: inputs show the pin, outputs the latch
    always_comb begin
        rd_next = 8'h00;
        if (b_mapped && (idx == `IDX_PORT_B_PIN_DATA)) begin
            rd_next = (port_b_pin_data_reg & port_b_direction_reg) |
                      (pb_i & ~port_b_direction_reg);
        end else if (b_mapped && (idx == `IDX_PORT_B_DIRECTION)) begin
            rd_next = port_b_direction_reg;
        end else if (e_mapped && (idx == `IDX_PORT_E_PIN_DATA)) begin
            rd_next = (port_e_pin_data_reg & pe_oe_next) |
                      (pe_i & ~pe_oe_next);
        end else if (e_mapped && (idx == `IDX_PORT_E_DIRECTION)) begin
            rd_next = port_e_direction_reg;
        end else if (fs_mapped && (idx == `IDX_PORT_E_FUNCTION_SELECT)) begin
            rd_next = port_e_function_select_reg;
        end
    end

    // Wishbone answer, one wait state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            wb_dat_o <= rd ? {24'h00_0000, rd_next} : 32'h0000_0000;
        end
    end

    // Registered pins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pb_o        <= 8'h00;
            pb_oe_o     <= 8'h00;
            pe_o        <= (mode_i == bus_pin_pkg::MODE_NORMAL_NARROW) ?
                           `PE3_RESET_DRIVE : 8'h00;
            pe_oe_o     <= (mode_i == bus_pin_pkg::MODE_NORMAL_NARROW) ?
                           `PE3_RESET_DRIVE : 8'h00;
            pe_pullup_o <= 8'h00;
        end else begin
            pb_o        <= pb_next;
            pb_oe_o     <= pb_oe_next;
            pe_o        <= pe_next;
            pe_oe_o     <= pe_oe_next;
            pe_pullup_o <= {8{pullup_e_enable_i}} & ~pe_oe_next &
                           `PULLUP_PIN_MASK;
        end
    end

    // Sampled bus data and low byte tag
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_rdata_o    <= 8'h00;
            tag_low_byte_o <= 1'b0;
        end else begin
            bus_rdata_o    <= pb_i;
            tag_low_byte_o <= !special || single ? 1'b0 :
                              port_e_function_select_reg[`FS_LOW_STROBE_PIN_ENABLE] &&
                              !pe_i[3];
        end
    end

    AST_IRQ_PINS_INPUT: assert property (@(posedge clk_i) disable iff (rst_i)
        pe_oe_o[1:0] == 2'b00)
        else $error("Interrupt pins driven");

    AST_PB_GPIO: assert property (@(posedge clk_i) disable iff (rst_i)
        single ##1 $stable(mode_i) |-> pb_oe_o == $past(port_b_direction_reg))
        else $error("Port B direction not followed");

    AST_PB_ADDR: assert property (@(posedge clk_i) disable iff (rst_i)
        !rst_i && narrow ##1 $stable(mode_i) |-> pb_o == $past(bus_addr_i) && pb_oe_o == 8'hff)
        else $error("Port B not carrying address");

    AST_PB_UNMAPPED: assert property (@(posedge clk_i) disable iff (rst_i)
        rd && !single && idx == `IDX_PORT_B_DIRECTION |=> wb_ack_o && wb_dat_o == 32'h0)
        else $error("Port B register visible when expanded");

    AST_PERIPH_FS_FIXED: assert property (@(posedge clk_i) disable iff (rst_i)
        periph && $stable(mode_i) |=> $stable(port_e_function_select_reg))
        else $error("Function select changed in peripheral mode");

    AST_FS_RESET: assert property (@(posedge clk_i)
        rst_i && mode_i == bus_pin_pkg::MODE_NORMAL_SINGLE ##1 $stable(mode_i) |->
        port_e_function_select_reg == 8'h90)
        else $error("Wrong function select reset");

    AST_PLL_NORMAL_LOCK: assert property (@(posedge clk_i) disable iff (rst_i)
        !special && $stable(mode_i) |=>
        $stable(port_e_function_select_reg[`FS_PLL_TEST_OUT_ENABLE]))
        else $error("PLL test bit written in normal mode");

    AST_ONCE: assert property (@(posedge clk_i) disable iff (rst_i)
        !special && written_reg[`FS_RW_PIN_ENABLE] && $stable(mode_i) |=>
        $stable(port_e_function_select_reg[`FS_RW_PIN_ENABLE]))
        else $error("Write-once bit changed twice");

    AST_NARROW_PE3: assert property (@(posedge clk_i)
        $fell(rst_i) && mode_i == bus_pin_pkg::MODE_NORMAL_NARROW |->
        pe_oe_o[3] && pe_o[3])
        else $error("Bit 3 not driven high after reset");

    AST_QUEUE_OUT: assert property (@(posedge clk_i) disable iff (rst_i)
        !rst_i && expanded && port_e_function_select_reg[`FS_QUEUE_STATUS_OUT_ENABLE] |=>
        pe_oe_o[6:5] == 2'b11)
        else $error("Queue status pins not outputs");

endmodule : bus_pin_assign

// ---- rtl/bus_pin_map.svh ----
// Register indices, field positions and reset values of the port pin block.
// Assumes inclusion by the block; definitions only.
`ifndef BUS_PIN_MAP_SVH
`define BUS_PIN_MAP_SVH

`define IDX_PORT_B_PIN_DATA         4'h1
`define IDX_PORT_B_DIRECTION        4'h3
`define IDX_PORT_E_PIN_DATA         4'h8
`define IDX_PORT_E_DIRECTION        4'h9
`define IDX_PORT_E_FUNCTION_SELECT  4'ha

`define FS_NO_DATA_GATE             7
`define FS_PLL_TEST_OUT_ENABLE      6
`define FS_QUEUE_STATUS_OUT_ENABLE  5
`define FS_BUS_CLOCK_PIN_DISABLE    4
`define FS_LOW_STROBE_PIN_ENABLE    3
`define FS_RW_PIN_ENABLE            2
`define FS_TRIM_REFERENCE_ENABLE    1
`define FS_DATA_GATE_SELECT         0

`define FS_RST_NORMAL_EXPANDED      8'h00
`define FS_RST_SPECIAL              8'h2c
`define FS_RST_PERIPHERAL           8'hd0
`define FS_RST_NORMAL_SINGLE        8'h90

`define ONCE_GROUP_MASK             8'had
`define PULLUP_PIN_MASK             8'h8f
`define PE3_RESET_DRIVE             8'h08

`endif

// ---- rtl/bus_pin_pkg.sv ----
// Types shared by the port pin block and its bench.
// Assumes bus_pin_map.svh holds every number.
package bus_pin_pkg;
    typedef enum logic [2:0] {
        MODE_NORMAL_SINGLE,
        MODE_NORMAL_NARROW,
        MODE_NORMAL_WIDE,
        MODE_SPECIAL_SINGLE,
        MODE_SPECIAL_NARROW,
        MODE_SPECIAL_WIDE,
        MODE_PERIPHERAL
    } mode_e;
endpackage : bus_pin_pkg

// ---- verification/ext_bus_agent.sv ----
// External bus agent: memories and peripherals on the far side of ports B and E.
// Assumes registered device pin outputs; the bench says when the agent drives.
`timescale 1ns/1ps
module ext_bus_agent (
    input  wire logic       clk_i,
    input  wire logic [7:0] pb_o_i,
    input  wire logic [7:0] pb_oe_i,
    input  wire logic [7:0] pe_o_i,
    input  wire logic [7:0] pe_oe_i,
    input  wire logic [7:0] pe_pullup_i,
    input  wire logic [7:0] ext_pb_i,
    input  wire logic [7:0] ext_pe_i,
    input  wire logic       ext_drive_i,
    input  wire logic       tag_req_i,
    output logic      [7:0] pb_pin_o,
    output logic      [7:0] pe_pin_o
);
    logic [7:0] float_reg = 8'h55;
    // Undriven pins without pull-up wander every cycle
    always_ff @(posedge clk_i) begin
        float_reg <= ~float_reg;
    end
    always_comb begin
        for (int k = 0; k < 8; k++) begin
            pb_pin_o[k] = pb_oe_i[k] ? pb_o_i[k] : (ext_drive_i ? ext_pb_i[k] : float_reg[k]);
            pe_pin_o[k] = pe_oe_i[k] ? pe_o_i[k] :
                          (ext_drive_i ? ext_pe_i[k] : (pe_pullup_i[k] | float_reg[k]));
        end
        if (tag_req_i) begin
            pe_pin_o[3] = 1'b0;
        end
    end
endmodule : ext_bus_agent

// ---- verification/bus_pin_assign_tb_top.sv ----
// Self-checking bench for the port B and port E pin assignment block.
// Assumes the package and the external bus agent are compiled before it.
`timescale 1ns/1ps
module bus_pin_assign_tb_top;
    logic               clk_i = 1'b0;
    logic               rst_i = 1'b1;
    bus_pin_pkg::mode_e mode  = bus_pin_pkg::MODE_NORMAL_SINGLE;
    logic        emu = 1'b0, strch = 1'b0, pup = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic        phase = 1'b0, drv = 1'b0, dbg = 1'b0, bclk = 1'b0, qh = 1'b0, ql = 1'b0;
    logic        lbs = 1'b0, brw = 1'b0, trim = 1'b0, pll = 1'b1, tag = 1'b0, ext_on = 1'b1;
    logic [7:0]  adr = 8'h00, baddr = 8'h00, bwd = 8'h00, ext_pb = 8'h00, ext_pe = 8'h00;
    logic [3:0]  sel = 4'hf;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdat;
    logic        ack, tag_o;
    logic [7:0]  pb_o, pb_oe, pe_o, pe_oe, pe_pu, pb_i, pe_i, brd;
    int          errors = 0, n_tests = 0, ncyc = 0;

    bus_pin_assign dut (.clk_i(clk_i), .rst_i(rst_i), .mode_i(mode),
        .emulate_port_e_bit_i(emu), .bus_clock_stretch_i(strch), .pullup_e_enable_i(pup),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack), .bus_addr_i(baddr),
        .bus_wdata_i(bwd), .bus_data_phase_i(phase), .bus_data_drive_i(drv),
        .data_bus_gate_i(dbg), .bus_phase_clock_i(bclk), .queue_status_hi_i(qh),
        .queue_status_lo_i(ql), .low_byte_strobe_i(lbs), .bus_rw_i(brw), .trim_ref_i(trim),
        .pll_test_signal_i(pll), .pb_i(pb_i), .pb_o(pb_o), .pb_oe_o(pb_oe), .pe_i(pe_i),
        .pe_o(pe_o), .pe_oe_o(pe_oe), .pe_pullup_o(pe_pu), .bus_rdata_o(brd),
        .tag_low_byte_o(tag_o));
    ext_bus_agent agent (.clk_i(clk_i), .pb_o_i(pb_o), .pb_oe_i(pb_oe), .pe_o_i(pe_o),
        .pe_oe_i(pe_oe), .pe_pullup_i(pe_pu), .ext_pb_i(ext_pb), .ext_pe_i(ext_pe),
        .ext_drive_i(ext_on), .tag_req_i(tag), .pb_pin_o(pb_i), .pe_pin_o(pe_i));

    initial begin
        forever #25 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        ncyc <= ncyc + 1;
        if (ncyc == 20000) begin
            errors++;
            summarize();
        end
    end

    task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task wb(input logic [7:0] a, input logic w, input logic [7:0] d, output logic [31:0] q);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wd <= {24'h0, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 16);
        q = rdat;
        if (n >= 16) begin
            errors++;
            $display("MISMATCH ack expected 1 seen none");
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb
    task wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        wb(a, 1'b1, d, q);
    endtask : wr
    task rdc(input logic [7:0] a, input logic [7:0] e, input string nm);
        logic [31:0] q;
        wb(a, 1'b0, 8'h00, q);
        chk(nm, q[7:0], e);
    endtask : rdc
    task tick;
        repeat (3) @(posedge clk_i);
    endtask : tick
    task rst_to(input bus_pin_pkg::mode_e m);
        @(posedge clk_i);
        mode <= m;
        rst_i <= 1'b1;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask : rst_to
    // Upper byte: function select read back, lower byte: port E enables
    function automatic logic [15:0] rst_exp(input bus_pin_pkg::mode_e m);
        case (m)
            bus_pin_pkg::MODE_NORMAL_SINGLE:  return 16'h9000;
            bus_pin_pkg::MODE_NORMAL_NARROW:  return 16'h0098;
            bus_pin_pkg::MODE_NORMAL_WIDE:    return 16'h0090;
            bus_pin_pkg::MODE_SPECIAL_SINGLE: return 16'h2c10;
            bus_pin_pkg::MODE_PERIPHERAL:     return 16'h0040;
            default:                          return 16'h2cfc;
        endcase
    endfunction : rst_exp

    task t_reset;
        logic [15:0] e;
        for (int i = 0; i < 7; i++) begin
            rst_to(bus_pin_pkg::mode_e'(i));
            e = rst_exp(mode);
            if (mode == bus_pin_pkg::MODE_NORMAL_NARROW) begin
                chk("pe3_rst", {6'h0, pe_oe[3], pe_o[3]}, 8'h03);
            end
            tick();
            chk("pe_oe_rst", pe_oe, e[7:0]);
            rdc(8'h28, e[15:8], "fs_rst");
        end
        chk("pll_out", {7'h0, pe_o[6]}, 8'h01);
        $display("test reset done");
    endtask : t_reset
    task t_port_b_pin_data;
        rst_to(bus_pin_pkg::MODE_NORMAL_SINGLE);
        ext_pb <= 8'h3c;
        wr(8'h0c, 8'h0f);
        wr(8'h04, 8'ha5);
        tick();
        chk("pb_oe", pb_oe, 8'h0f);
        chk("pb_out", {4'h0, pb_o[3:0]}, 8'h05);
        rdc(8'h04, 8'h35, "pb_rd");
        rdc(8'h3c, 8'h00, "unmapped");
        rst_to(bus_pin_pkg::MODE_NORMAL_WIDE);
        wr(8'h0c, 8'hff);
        rdc(8'h0c, 8'h00, "pb_dir_gone");
        baddr <= 8'h5a;
        bwd <= 8'hc3;
        drv <= 1'b1;
        tick();
        chk("pb_addr", pb_o, 8'h5a);
        phase <= 1'b1;
        tick();
        chk("pb_data", pb_o, 8'hc3);
        drv <= 1'b0;
        tick();
        chk("pb_rdata", brd, 8'h3c);
        rst_to(bus_pin_pkg::MODE_NORMAL_NARROW);
        tick();
        chk("pb_narrow", pb_o, 8'h5a);
        phase <= 1'b0;
        $display("test port_b done");
    endtask : t_port_b_pin_data
    task t_port_e_pin_data;
        rst_to(bus_pin_pkg::MODE_NORMAL_SINGLE);
        pup <= 1'b1;
        tick();
        chk("pe_pu_in", pe_pu, 8'h8f);
        wr(8'h24, 8'hff);
        wr(8'h20, 8'hff);
        tick();
        chk("pe_oe_all", pe_oe, 8'hfc);
        chk("pe_pu_out", pe_pu, 8'h03);
        rdc(8'h20, 8'hfc, "pe_rd");
        ext_on <= 1'b0;
        rdc(8'h20, 8'hff, "pe_rd_pu");
        ext_on <= 1'b1;
        pup <= 1'b0;
        emu <= 1'b1;
        rst_to(bus_pin_pkg::MODE_SPECIAL_WIDE);
        wr(8'h24, 8'hff);
        emu <= 1'b0;
        rdc(8'h24, 8'h00, "pe_dir_emu");
        rst_to(bus_pin_pkg::MODE_PERIPHERAL);
        wr(8'h24, 8'hff);
        wr(8'h28, 8'h00);
        tick();
        chk("pe_oe_per", pe_oe, 8'h40);
        $display("test port_e done");
    endtask : t_port_e_pin_data
    task t_once;
        rst_to(bus_pin_pkg::MODE_NORMAL_SINGLE);
        wr(8'h28, 8'h00);
        wr(8'h28, 8'hff);
        rdc(8'h28, 8'h02, "fs_once");
        rst_to(bus_pin_pkg::MODE_SPECIAL_SINGLE);
        strch <= 1'b1;
        tick();
        chk("pe4_strch", {7'h0, pe_oe[4]}, 8'h00);
        wr(8'h28, 8'h12);
        rdc(8'h28, 8'h3e, "fs_first");
        wr(8'h28, 8'hc1);
        rdc(8'h28, 8'hc1, "fs_later");
        strch <= 1'b0;
        rst_to(bus_pin_pkg::MODE_NORMAL_NARROW);
        wr(8'h28, 8'h08);
        tick();
        chk("pe3_narrow", {6'h0, pe_oe[3], pe_o[3]}, 8'h03);
        rst_to(bus_pin_pkg::MODE_NORMAL_WIDE);
        lbs <= 1'b1;
        wr(8'h28, 8'h0c);
        tick();
        chk("pe32_wide", {4'h0, pe_oe[3:2], pe_o[3:2]}, 8'h0e);
        $display("test write_once done");
    endtask : t_once
    task t_alt;
        rst_to(bus_pin_pkg::MODE_SPECIAL_WIDE);
        dbg <= 1'b1;
        qh <= 1'b1;
        tick();
        chk("pe_alt", {pe_o[7:2], 2'b00}, 8'hc8);
        chk("tag_off", {7'h0, tag_o}, 8'h00);
        tag <= 1'b1;
        tick();
        chk("tag_on", {7'h0, tag_o}, 8'h01);
        tag <= 1'b0;
        wr(8'h28, 8'h00);
        wr(8'h28, 8'h41);
        tick();
        chk("pe_pll", {pe_oe[7:6], pe_o[7:6], 4'h0}, 8'hf0);
        qh <= 1'b0;
        wr(8'h28, 8'h62);
        tick();
        chk("pe6_queue", {7'h0, pe_o[6]}, 8'h00);
        dbg <= 1'b0;
        trim <= 1'b1;
        wr(8'h28, 8'h82);
        tick();
        chk("pe7_trim", {6'h0, pe_oe[7], pe_o[7]}, 8'h03);
        $display("test alt_fn done");
    endtask : t_alt
    task summarize;
        $display("Checks %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize

    initial begin
        t_reset();
        t_port_b_pin_data();
        t_port_e_pin_data();
        t_once();
        t_alt();
        summarize();
    end
endmodule : bus_pin_assign_tb_top
